// ==== verilog/usa_pkg.sv ====
// constants, field layouts and carrier types for the uart status / aux block
// assumes one 250 MHz clock and an APB master with 32-bit data
package usa_pkg;
	localparam int ADDR_W = 6;
	localparam int DATA_W = 32;
	// register indices, byte address is index * 4
	localparam logic [3:0] IDX_DIV_LOW = 4'h0;
	localparam logic [3:0] IDX_DIV_HIGH = 4'h1;
	localparam logic [3:0] IDX_LINK_CTRL = 4'h3;
	localparam logic [3:0] IDX_LINK_STATUS = 4'h5;
	localparam logic [3:0] IDX_MODEM_STATUS = 4'h6;
	localparam logic [3:0] IDX_AUX = 4'h7;
	localparam logic [3:0] IDX_CONFIG = 4'h8;
	localparam logic [3:0] IDX_MODEM_CTRL = 4'h9;
	localparam int IDX_LSB = 2;
	// link control / bank select
	localparam int BANK_SEL_BIT = 7;
	localparam logic [7:0] LINK_CTRL_BANK2 = 8'he0;
	// config register fields
	localparam int CFG_W = 10;
	localparam int CFG_EXT = 0;
	localparam int CFG_LOCK = 1;
	localparam int CFG_LOOP = 2;
	localparam int CFG_MODE_LO = 3;
	localparam int CFG_IR_MODEM_STATUS_SELECT = 6;
	localparam int CFG_MSIE = 7;
	localparam int CFG_PRESCALE_LO = 8;
	// modem control fields
	localparam int MC_DTR = 0;
	localparam int MC_RTS = 1;
	localparam int MC_RILP = 2;
	localparam int MC_DCDLP = 3;
	// operation modes
	localparam logic [2:0] MODE_UART = 3'h0;
	localparam logic [2:0] MODE_ASK_IR = 3'h2;
	localparam logic [2:0] MODE_SIR = 3'h3;
	localparam logic [2:0] MODE_CONSUMER_IR = 3'h6;
	// aux status / control fields
	localparam int AUX_RX_TOUT = 0;
	localparam int AUX_EOT = 2;
	localparam int AUX_WDG = 4;
	localparam int AUX_RX_ACTIVE_FLAG = 5;
	localparam int AUX_IR_TX_UNDERRUN = 6;
	localparam logic [7:0] AUX_TX_RST_MASK = 8'h44;
	localparam logic [7:0] AUX_RX_RST_MASK = 8'h33;
	// link status and modem status
	localparam int LSR_TX_EMPTY = 6;
	localparam int LSR_ERR_SUMMARY = 7;
	localparam logic [7:0] MSR_IR_FIXED = 8'h30;
	localparam int RI_BIT = 2;
	// baud chain: mclk -> 24 MHz reference -> prescale -> divisor -> 16
	localparam int MCLK_KHZ = 250000;
	localparam int REF_KHZ = 24000;
	localparam int RATE_GCD_KHZ = 2000;
	localparam logic [7:0] REF_STEP = 8'(REF_KHZ / RATE_GCD_KHZ);
	localparam logic [7:0] REF_LIM = 8'(MCLK_KHZ / RATE_GCD_KHZ);
	localparam logic [1:0] PRESCALE_13 = 2'h0;
	localparam logic [1:0] PRESCALE_1625 = 2'h1;
	localparam logic [1:0] PRESCALE_1 = 2'h2;
	localparam logic [4:0] PRE_STEP_13 = 5'h1;
	localparam logic [4:0] PRE_STEP_1625 = 5'h8;
	localparam logic [4:0] PRE_LIM_13 = 5'hd;
	localparam logic [4:0] PRE_LIM_1 = 5'h1;
	localparam logic [3:0] OVERSAMPLE_LAST = 4'hf;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [DATA_W-1:0] pwdata;
	} usa_apb_req_t;

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [DATA_W-1:0] prdata;
	} usa_apb_rsp_t;

	typedef struct packed {
		logic ctsN;
		logic dsrN;
		logic riN;
		logic dcdN;
	} usa_modem_in_t;

	typedef struct packed {
		logic txHoldEmpty;
		logic txFrontIdle;
		logic rxErrInFifo;
		logic basicMode;
		logic rxTimeout;
		logic rxFifoRead;
		logic txFifoWrite;
		logic txStarved;
		logic irPulse;
		logic txSoftReset;
		logic rxSoftReset;
	} usa_core_evt_t;

	typedef struct packed {
		logic dtrN;
		logic rtsN;
		logic modemStatusEvent;
		logic txHalt;
		logic rxActive;
		logic endOfTxMark;
		logic extendedMode;
		logic loopback;
		logic [2:0] mode;
		logic baudX16Tick;
		logic baudTick;
		logic fallbackPulse;
	} usa_ctl_out_t;

	typedef struct packed {
		usa_apb_rsp_t rsp;
		usa_ctl_out_t out;
		logic [7:0] linkCtrl;
		logic [CFG_W-1:0] cfg;
		logic [3:0] mctrl;
		logic [7:0] scratch;
		logic [7:0] aux;
		logic [15:0] divisor;
		logic [3:0] deltas;
		logic [3:0] lineAsserted;
		logic primed;
		logic errSummary;
		logic [7:0] refAcc;
		logic [4:0] preAcc;
		logic [15:0] divCnt;
		logic [3:0] bitCnt;
	} usa_state_t;
endpackage

// ==== verilog/usa_status_aux.sv ====
// link status upper bits, modem status, scratch / aux register, legacy divisor
// assumes an APB master on mclk and core event pulses synchronous to mclk
`timescale 1ns/1ps

module usa_status_aux
	import usa_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// apb slave
	input wire usa_apb_req_t apbReq,
	output usa_apb_rsp_t apbRsp,
	// modem lines
	input wire usa_modem_in_t modemIn,
	// core events
	input wire usa_core_evt_t coreEvt,
	// control outputs
	output usa_ctl_out_t ctlOut
);

	usa_state_t s;
	usa_state_t n;

	function automatic logic isDivPort(input logic [3:0] idx, input logic [7:0] lcr);
		logic bank1;
		bank1 = lcr[BANK_SEL_BIT] && (lcr != LINK_CTRL_BANK2);
		return bank1 && ((idx == IDX_DIV_LOW) || (idx == IDX_DIV_HIGH));
	endfunction

	function automatic logic [2:0] effMode(input logic [CFG_W-1:0] cfg);
		return cfg[CFG_EXT] ? cfg[CFG_MODE_LO +: 3] : MODE_UART;
	endfunction

	////////////////////////////////////////////////////////////////////////

	logic [3:0] idx;
	logic bank0;
	logic setup;
	logic act;
	logic wr;
	logic rd;
	logic ext;
	logic irMode;
	logic cir;
	logic locked;
	logic modeChg;
	logic [3:0] pinAss;
	logic [3:0] loopAss;
	logic [3:0] src;
	logic [3:0] chg;
	logic [3:0] newDelta;
	logic [3:0] deltaClr;
	logic [7:0] rdByte;
	logic mapped;
	logic errSet;
	logic errClr;
	logic [7:0] aux;
	logic [7:0] sum8;
	logic [4:0] preStep;
	logic [4:0] preLim;
	logic [4:0] sum5;
	logic preTick;

	assign apbRsp = s.rsp;
	assign ctlOut = s.out;

	always_comb begin
		n = s;
		idx = apbReq.paddr[IDX_LSB +: 4];
		bank0 = !s.linkCtrl[BANK_SEL_BIT];
		setup = apbReq.psel && !apbReq.penable;
		act = apbReq.psel && apbReq.penable && s.rsp.pready && !s.rsp.pslverr;
		wr = act && apbReq.pwrite;
		rd = act && !apbReq.pwrite;
		ext = s.cfg[CFG_EXT];
		irMode = effMode(s.cfg) != MODE_UART;
		cir = effMode(s.cfg) == MODE_CONSUMER_IR;
		locked = !ext && s.cfg[CFG_LOCK];
		n.out.baudX16Tick = 1'b0;
		n.out.baudTick = 1'b0;
		n.out.fallbackPulse = 1'b0;

		////////////////////////////////////////////////////////////////
		// modem inputs, loopback routing and edge detection
		// the lines only feed this status path, never tx or rx
		pinAss = ~{modemIn.dcdN, modemIn.riN, modemIn.dsrN, modemIn.ctsN};
		if (ext) begin
			loopAss = {s.mctrl[MC_RTS], s.mctrl[MC_DTR], s.mctrl[MC_DTR], s.mctrl[MC_RTS]};
		end else begin
			loopAss = {s.mctrl[MC_DCDLP], s.mctrl[MC_RILP], s.mctrl[MC_DTR], s.mctrl[MC_RTS]};
		end
		src = s.cfg[CFG_LOOP] ? loopAss : pinAss;
		chg = s.primed ? (src ^ s.lineAsserted) : 4'h0;
		newDelta = chg;
		newDelta[RI_BIT] = s.primed && s.lineAsserted[RI_BIT] && !src[RI_BIT];
		n.lineAsserted = src;
		n.primed = 1'b1;

		////////////////////////////////////////////////////////////////
		// read data, captured in the setup cycle
		mapped = 1'b1;
		rdByte = 8'h0;
		unique case (idx)
			IDX_DIV_LOW: begin
				mapped = isDivPort(idx, s.linkCtrl);
				rdByte = s.divisor[7:0];
			end
			IDX_DIV_HIGH: begin
				mapped = isDivPort(idx, s.linkCtrl);
				rdByte = s.divisor[15:8];
			end
			IDX_LINK_CTRL: begin
				rdByte = s.linkCtrl;
			end
			IDX_LINK_STATUS: begin
				mapped = bank0;
				rdByte[LSR_TX_EMPTY] = coreEvt.txHoldEmpty && coreEvt.txFrontIdle;
				rdByte[LSR_ERR_SUMMARY] = s.errSummary;
			end
			IDX_MODEM_STATUS: begin
				mapped = bank0;
				if (irMode && s.cfg[CFG_IR_MODEM_STATUS_SELECT]) begin
					rdByte = MSR_IR_FIXED;
				end else begin
					rdByte = {src, s.deltas};
				end
			end
			IDX_AUX: begin
				mapped = bank0;
				rdByte = ext ? s.aux : s.scratch;
			end
			IDX_CONFIG: begin
				rdByte = s.cfg[7:0];
			end
			IDX_MODEM_CTRL: begin
				rdByte = {4'h0, s.mctrl};
			end
			default: begin
				mapped = 1'b0;
			end
		endcase
		n.rsp.pready = setup;
		n.rsp.pslverr = setup && !mapped;
		if (setup) begin
			n.rsp.prdata = (apbReq.pwrite || !mapped) ? '0 : {24'h0, rdByte};
		end

		////////////////////////////////////////////////////////////////
		// plain register writes
		if (wr && idx == IDX_LINK_CTRL) begin
			n.linkCtrl = apbReq.pwdata[7:0];
		end
		if (wr && idx == IDX_CONFIG) begin
			n.cfg = apbReq.pwdata[CFG_W-1:0];
		end
		if (wr && idx == IDX_MODEM_CTRL) begin
			n.mctrl = apbReq.pwdata[3:0];
		end
		if (wr && idx == IDX_AUX && !ext) begin
			n.scratch = apbReq.pwdata[7:0];
		end

		////////////////////////////////////////////////////////////////
		// legacy divisor ports and fallback
		if (act && isDivPort(idx, s.linkCtrl) && !locked) begin
			n.out.fallbackPulse = 1'b1;
			n.cfg[CFG_EXT] = 1'b0;
			if (ext) begin
				n.cfg[CFG_MODE_LO +: 3] = MODE_UART;
			end
			if (apbReq.pwrite) begin
				if (idx == IDX_DIV_LOW) begin
					n.divisor[7:0] = apbReq.pwdata[7:0];
				end else begin
					n.divisor[15:8] = apbReq.pwdata[7:0];
				end
			end
		end
		modeChg = effMode(n.cfg) != effMode(s.cfg);

		////////////////////////////////////////////////////////////////
		// modem status deltas and event, set wins over clear
		deltaClr = 4'h0;
		if (rd && idx == IDX_MODEM_STATUS) begin
			deltaClr = s.rsp.prdata[3:0];
		end
		if (modeChg && !s.cfg[CFG_IR_MODEM_STATUS_SELECT]) begin
			deltaClr = 4'hf;
		end
		n.deltas = (s.deltas & ~deltaClr) | newDelta;
		n.out.modemStatusEvent = n.cfg[CFG_MSIE] && (n.deltas != 4'h0);

		////////////////////////////////////////////////////////////////
		// error summary in link status
		errSet = coreEvt.rxErrInFifo && (effMode(s.cfg) != MODE_CONSUMER_IR);
		errClr = rd && idx == IDX_LINK_STATUS && s.rsp.prdata[LSR_ERR_SUMMARY];
		if (!ext && coreEvt.basicMode) begin
			n.errSummary = 1'b0;
		end else begin
			n.errSummary = (s.errSummary && !errClr) || errSet;
		end

		////////////////////////////////////////////////////////////////
		// aux status / control
		aux = s.aux;
		if (coreEvt.txFifoWrite) begin
			aux[AUX_EOT] = 1'b0;
		end
		if (wr && idx == IDX_AUX && ext) begin
			aux[AUX_EOT] = apbReq.pwdata[AUX_EOT];
			if (apbReq.pwdata[AUX_RX_ACTIVE_FLAG]) begin
				aux[AUX_RX_ACTIVE_FLAG] = 1'b0;
			end
			if (apbReq.pwdata[AUX_IR_TX_UNDERRUN]) begin
				aux[AUX_IR_TX_UNDERRUN] = 1'b0;
			end
		end
		if (rd && idx == IDX_AUX && ext && s.rsp.prdata[AUX_WDG]) begin
			aux[AUX_WDG] = 1'b0;
		end
		if (coreEvt.rxFifoRead) begin
			aux[AUX_RX_TOUT] = 1'b0;
		end
		if (coreEvt.txSoftReset) begin
			aux = aux & ~AUX_TX_RST_MASK;
		end
		if (coreEvt.rxSoftReset) begin
			aux = aux & ~AUX_RX_RST_MASK;
		end
		if (modeChg) begin
			aux = 8'h0;
		end
		if (coreEvt.rxTimeout && ext) begin
			aux[AUX_RX_TOUT] = 1'b1;
		end
		if (cir && coreEvt.irPulse) begin
			aux[AUX_WDG] = 1'b1;
			aux[AUX_RX_ACTIVE_FLAG] = 1'b1;
		end
		if (cir && coreEvt.txStarved && !s.aux[AUX_EOT]) begin
			aux[AUX_IR_TX_UNDERRUN] = 1'b1;
		end
		if (effMode(n.cfg) != MODE_CONSUMER_IR) begin
			aux[AUX_IR_TX_UNDERRUN] = 1'b0;
		end
		n.aux = aux;

		////////////////////////////////////////////////////////////////
		// baud chain
		sum8 = s.refAcc + REF_STEP;
		preTick = 1'b0;
		if (sum8 >= REF_LIM) begin
			n.refAcc = sum8 - REF_LIM;
			unique case (s.cfg[CFG_PRESCALE_LO +: 2])
				PRESCALE_1625: begin
					preStep = PRE_STEP_1625;
					preLim = PRE_LIM_13;
				end
				PRESCALE_1: begin
					preStep = PRE_STEP_13;
					preLim = PRE_LIM_1;
				end
				default: begin
					preStep = PRE_STEP_13;
					preLim = PRE_LIM_13;
				end
			endcase
			sum5 = s.preAcc + preStep;
			if (sum5 >= preLim) begin
				n.preAcc = sum5 - preLim;
				preTick = 1'b1;
			end else begin
				n.preAcc = sum5;
			end
		end else begin
			n.refAcc = sum8;
			preStep = PRE_STEP_13;
			preLim = PRE_LIM_13;
			sum5 = s.preAcc;
		end
		if (n.divisor != s.divisor) begin
			n.divCnt = n.divisor;
		end else if (preTick && s.divisor != 16'h0) begin
			if (s.divCnt <= 16'h1) begin
				n.divCnt = s.divisor;
				n.out.baudX16Tick = 1'b1;
				n.bitCnt = s.bitCnt + 4'h1;
				n.out.baudTick = s.bitCnt == OVERSAMPLE_LAST;
			end else begin
				n.divCnt = s.divCnt - 16'h1;
			end
		end

		////////////////////////////////////////////////////////////////
		// registered control outputs
		n.out.dtrN = n.cfg[CFG_LOOP] || !n.mctrl[MC_DTR];
		n.out.rtsN = n.cfg[CFG_LOOP] || !n.mctrl[MC_RTS];
		n.out.txHalt = n.aux[AUX_IR_TX_UNDERRUN];
		n.out.rxActive = n.aux[AUX_RX_ACTIVE_FLAG];
		n.out.endOfTxMark = n.aux[AUX_EOT];
		n.out.extendedMode = n.cfg[CFG_EXT];
		n.out.loopback = n.cfg[CFG_LOOP];
		n.out.mode = effMode(n.cfg);
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			s <= '0;
			s.out.dtrN <= 1'b1;
			s.out.rtsN <= 1'b1;
		end else begin
			s <= n;
		end
	end

endmodule

// ==== sim/usa_modem_model.sv ====
// modem line partner: drives the active-low modem inputs of the block
// assumes the bench commands line levels; lines move just after a clock edge
`timescale 1ns/1ps
module usa_modem_model
	import usa_pkg::*;
(
	// clock
	input wire logic mclk,
	// commanded levels, extra lag
	input wire usa_modem_in_t want,
	input wire logic slow,
	// lines into the block
	output usa_modem_in_t modemIn
);
	usa_modem_in_t stage;
	initial modemIn = '1;
	always @(posedge mclk) begin
		stage <= want;
		modemIn <= slow ? stage : want;
	end
endmodule

// ==== sim/usa_status_aux_assertions.sv ====
// concurrent checks on the uart status / aux block ports
// assumes binding onto usa_status_aux, one clock domain
`timescale 1ns/1ps
module usa_status_aux_assertions
	import usa_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// watched ports
	input wire usa_apb_req_t apbReq,
	input wire usa_apb_rsp_t apbRsp,
	input wire usa_modem_in_t modemIn,
	input wire usa_core_evt_t coreEvt,
	input wire usa_ctl_out_t ctlOut
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	sequence setupS;
		apbReq.psel && !apbReq.penable;
	endsequence
	sequence cirIdleS;
		ctlOut.mode == MODE_CONSUMER_IR && !apbReq.psel;
	endsequence
	apb_ready_a: assert property (setupS |=> apbRsp.pready)
		else $error("no ready after setup");
	underrun_set_a: assert property (cirIdleS ##0 coreEvt.txStarved && !ctlOut.endOfTxMark |-> ##[1:2] ctlOut.txHalt)
		else $error("underrun not raised");
	underrun_clear_a: assert property (ctlOut.mode != MODE_CONSUMER_IR && $past(ctlOut.mode) != MODE_CONSUMER_IR
		&& $past(ctlOut.mode, 2) != MODE_CONSUMER_IR |-> !ctlOut.txHalt)
		else $error("underrun outside consumer ir");
	eot_clear_a: assert property (coreEvt.txFifoWrite && !apbReq.psel |-> ##[1:2] !ctlOut.endOfTxMark)
		else $error("end mark kept after fifo write");
	rx_active_a: assert property (cirIdleS ##0 coreEvt.irPulse |-> ##[1:2] ctlOut.rxActive)
		else $error("receiver not activated");
	tx_soft_rst_a: assert property (coreEvt.txSoftReset && !coreEvt.txStarved && !apbReq.psel
		|-> ##[1:2] !ctlOut.endOfTxMark && !ctlOut.txHalt)
		else $error("tx soft reset left aux bits");
	loop_lines_a: assert property (ctlOut.loopback && $past(ctlOut.loopback) |-> ctlOut.dtrN && ctlOut.rtsN)
		else $error("modem outputs driven in loopback");
	fallback_mode_a: assert property (ctlOut.fallbackPulse |-> ##[0:1] !ctlOut.extendedMode && ctlOut.mode == 3'h0)
		else $error("fallback left extended mode");
	baud_gap_a: assert property (ctlOut.baudX16Tick |=> (!ctlOut.baudX16Tick) [*8])
		else $error("x16 ticks faster than reference");
endmodule
bind usa_status_aux usa_status_aux_assertions chk (.mclk(mclk), .rst(rst), .apbReq(apbReq), .apbRsp(apbRsp),
	.modemIn(modemIn), .coreEvt(coreEvt), .ctlOut(ctlOut));

// ==== sim/tb_usa_status_aux.sv ====
// self-checking bench for the uart status / aux block
// assumes package, design, modem model and checker compiled first
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
	$display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module tb_usa_status_aux
	import usa_pkg::*;
;
	logic mclk = 0;
	logic rst = 1;
	logic slow = 0;
	logic serr;
	int err_count = 0;
	int cmp_count = 0;
	int cy[3] = '{13000, 3250, 1250};
	int ex[3] = '{96, 192, 120};
	usa_apb_req_t req = '0;
	usa_apb_rsp_t rsp;
	usa_modem_in_t want = '1;
	usa_modem_in_t modemIn;
	usa_core_evt_t ev = '0;
	usa_ctl_out_t ctl;
	always #2 mclk = ~mclk;
	usa_status_aux dut (.mclk(mclk), .rst(rst), .apbReq(req), .apbRsp(rsp), .modemIn(modemIn), .coreEvt(ev),
		.ctlOut(ctl));
	usa_modem_model peer (.mclk(mclk), .want(want), .slow(slow), .modemIn(modemIn));
	////////////////////////////////////////////////////////////////
	task automatic xfer(input logic w, input logic [3:0] i, input logic [31:0] d, output logic [31:0] r);
		int n;
		n = 0;
		@(posedge mclk);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: {i, 2'b00}, pwdata: d};
		@(posedge mclk);
		req.penable <= 1'b1;
		do @(posedge mclk); while (rsp.pready !== 1'b1 && n++ < 50);
		r = rsp.prdata;
		serr = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask
	task automatic wr(input logic [3:0] i, input logic [31:0] d);
		logic [31:0] r;
		xfer(1'b1, i, d, r);
	endtask
	task automatic chk(input logic [3:0] i, input logic [7:0] e, input logic [7:0] m = 8'hff);
		logic [31:0] r;
		xfer(1'b0, i, 32'h0, r);
		`CHK(r & {24'hffffff, m}, {24'h0, e})
	endtask
	task automatic pe(input logic [10:0] m);
		@(posedge mclk);
		ev <= usa_core_evt_t'(ev | m);
		@(posedge mclk);
		ev <= usa_core_evt_t'(ev & ~m);
	endtask
	task automatic lines(input logic [3:0] v);
		@(posedge mclk);
		want <= usa_modem_in_t'(v);
		repeat (6) @(posedge mclk);
	endtask
	task automatic cnt(input int c, input int e);
		int n;
		n = 0;
		repeat (c) begin
			@(posedge mclk);
			n += int'(ctl.baudX16Tick === 1'b1);
		end
		`CHK(n >= e - 1 && n <= e + 1, 1'b1)
	endtask
	task automatic done(input string s);
		$display("test %s ended at %0t", s, $time);
	endtask
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (60000) @(posedge mclk);
		err_count++;
		complete_run();
	end
	initial begin
		repeat (20) @(posedge mclk);
		rst <= 1'b0;
		wr(4'h3, 32'h0);
		chk(4'h6, 8'h00);
		lines(4'h0);
		chk(4'h6, 8'hfb);
		chk(4'h6, 8'hf0);
		lines(4'h2);
		chk(4'h6, 8'hb4);
		chk(4'h6, 8'hb0);
		wr(4'h8, 32'h80);
		slow <= 1'b1;
		lines(4'h0);
		`CHK(ctl.modemStatusEvent, 1'b0)
		lines(4'h8);
		`CHK(ctl.modemStatusEvent, 1'b1)
		chk(4'h6, 8'he1);
		repeat (2) @(posedge mclk);
		`CHK(ctl.modemStatusEvent, 1'b0)
		lines(4'hf);
		wr(4'h9, 32'h05);
		wr(4'h8, 32'h04);
		chk(4'h6, 8'h60, 8'hf0);
		`CHK(ctl.dtrN, 1'b1)
		wr(4'h9, 32'h0);
		wr(4'h8, 32'h59);
		chk(4'h6, 8'h30);
		wr(4'h8, 32'h19);
		lines(4'h7);
		wr(4'h8, 32'h01);
		chk(4'h6, 8'h10);
		done("modem");
		wr(4'h8, 32'h0);
		wr(4'h7, 32'ha5);
		chk(4'h7, 8'ha5);
		wr(4'h8, 32'h01);
		chk(4'h7, 8'h00);
		@(posedge mclk) ev <= usa_core_evt_t'(11'h400);
		chk(4'h5, 8'h00, 8'hc0);
		@(posedge mclk) ev <= usa_core_evt_t'(11'h700);
		chk(4'h5, 8'hc0, 8'hc0);
		@(posedge mclk) ev <= usa_core_evt_t'(11'h600);
		chk(4'h5, 8'h40, 8'h40);
		chk(4'h5, 8'h40, 8'hc0);
		wr(4'h8, 32'h0);
		@(posedge mclk) ev <= usa_core_evt_t'(11'h780);
		chk(4'h5, 8'h40, 8'hc0);
		@(posedge mclk) ev <= usa_core_evt_t'(11'h600);
		done("status");
		wr(4'h8, 32'h31);
		pe(11'h008);
		chk(4'h7, 8'h40);
		`CHK(ctl.txHalt, 1'b1)
		wr(4'h7, 32'h40);
		chk(4'h7, 8'h00);
		wr(4'h7, 32'h04);
		pe(11'h010);
		chk(4'h7, 8'h00);
		wr(4'h7, 32'h04);
		pe(11'h008);
		chk(4'h7, 8'h04);
		pe(11'h004);
		chk(4'h7, 8'h34);
		chk(4'h7, 8'h24);
		wr(4'h7, 32'h20);
		chk(4'h7, 8'h00);
		pe(11'h040);
		chk(4'h7, 8'h01);
		pe(11'h020);
		chk(4'h7, 8'h00);
		pe(11'h00c);
		pe(11'h002);
		chk(4'h7, 8'h30);
		pe(11'h001);
		chk(4'h7, 8'h00);
		pe(11'h008);
		wr(4'h8, 32'h19);
		chk(4'h7, 8'h00);
		done("aux");
		wr(4'h8, 32'h231);
		wr(4'h3, 32'h80);
		wr(4'h0, 32'h01);
		@(posedge mclk);
		`CHK(ctl.extendedMode, 1'b0)
		`CHK(ctl.fallbackPulse, 1'b1)
		wr(4'h1, 32'h0);
		for (int p = 0; p < 3; p++) begin
			wr(4'h8, 32'(p) << 8);
			cnt(cy[p], ex[p]);
		end
		wr(4'h8, 32'h202);
		wr(4'h0, 32'h05);
		cnt(1250, 120);
		wr(4'h8, 32'h200);
		wr(4'h0, 32'h02);
		cnt(1250, 60);
		wr(4'h3, 32'he0);
		chk(4'h5, 8'h00);
		`CHK(serr, 1'b1)
		done("divisor");
		complete_run();
	end
endmodule
